// ### hw/lcc_pkg.sv
// package: register map, field positions and mode codes of the logic cell core
package lcc_pkg;
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFS_CONTROL       = 8'h00;
  localparam logic [7:0]  OFS_POLARITY      = 8'h04;
  localparam logic [7:0]  OFS_SEL0          = 8'h08;
  localparam logic [7:0]  OFS_GLS0          = 8'h18;
  localparam logic [7:0]  OFS_IRQ           = 8'h28;
  localparam logic [7:0]  OFS_MIRROR        = 8'h2C;
  localparam logic [7:0]  OFS_STEP          = 8'h04;
  // control register fields
  localparam int unsigned CTL_EN            = 7;
  localparam int unsigned CTL_OUT           = 5;
  localparam int unsigned CTL_RISE          = 4;
  localparam int unsigned CTL_FALL          = 3;
  localparam int unsigned CTL_MODE_HI       = 2;
  localparam logic [7:0]  CTL_WMASK         = 8'h9F;
  localparam logic [7:0]  CTL_RESET         = 8'h00;
  // polarity register fields
  localparam int unsigned POL_OUT_INV       = 7;
  localparam logic [7:0]  POL_WMASK         = 8'h8F;
  localparam logic [7:0]  SEL_WMASK         = 8'h3F;
  // irq register fields
  localparam int unsigned IRQ_FLAG          = 0;
  localparam int unsigned IRQ_CELL_EN       = 1;
  localparam int unsigned IRQ_PERIPH_EN     = 2;
  localparam int unsigned IRQ_GLOBAL_EN     = 3;
  localparam int unsigned SEL_W             = 6;
  localparam int unsigned NGATE             = 4;
  typedef enum logic [2:0] {
    LCC_AND_OR   = 3'b000,
    LCC_OR_XOR   = 3'b001,
    LCC_AND4     = 3'b010,
    LCC_SR_LATCH = 3'b011,
    LCC_DFF_SR   = 3'b100,
    LCC_DFF2_R   = 3'b101,
    LCC_JK_R     = 3'b110,
    LCC_LATCH_SR = 3'b111
  } lcc_mode_t;
endpackage : lcc_pkg

// ### hw/lcc_core.sv
// logic cell core: input select, gating, logic function, polarity, edge flag, apb slave
`timescale 1ns/100ps

// Summary of operation
// - mode 111 transparent latch with set/reset
// - mode 110 J-K flip-flop with reset
// - mode 101 two-input D flip-flop, reset
// - mode 100 D flip-flop with set, reset
// - mode 011 set-reset latch from gates
// - mode 010 AND of four gates
// - 001 OR-XOR, 000 AND-OR
// - four gate inputs, one output fanned out
// - output invert bit inverts final result
// - gate invert bits invert each gate
// - polarity change counts as output edge
// - enable clear forces output zero
// - read-only output bit shows final output
// - rising and falling edge detectors present
// - rise enable sets flag on rise
// - fall enable sets flag on fall
// - flag cleared by software, edge wins
// - request needs all four enables set
// - mirror samples all cell outputs together
// - reset clears control, keeps selects/gates
// - runs from its inputs, no cpu needed
// - keep fast oscillator on when enabled and selected
// - four 6-bit data selects from bus
// - gates combine enabled true/negated inputs
// - gate select bit pairs, data4 true top
module lcc_core #(
  parameter int unsigned     IN_W       = 64,
  parameter int unsigned     NCELL      = 4,
  parameter logic [5:0]      FAST_OSC_SEL = 6'h34
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  input  wire logic [IN_W-1:0]           cell_in_i,
  input  wire logic [NCELL-1:0]          peer_out_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [lcc_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  output logic                           cell_out_o,
  output logic                           irq_o,
  output logic                           osc_keep_o
);
  import lcc_pkg::*;
  // the cell is modelled on the core clock: inputs are sampled once per
  // clock, the output flop follows one edge after its inputs, and the
  // flip-flop modes (100, 101, 110) treat the first clock that sees gate 1 high as its edge

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]        control_r;
  logic [7:0]        polarity_r;
  logic [7:0]        sel_r [NGATE];
  logic [7:0]        gls_r [NGATE];
  logic              irq_flag_r;
  logic              cell_ie_r;
  logic              periph_ie_r;
  logic              global_ie_r;
  logic [NCELL-1:0]  mirror_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              cell_out_r;
  logic              irq_r;
  logic              osc_keep_r;
  logic              state_r;
  logic              g1_prev_r;
  logic              out_inv_r;
  logic [6:0]        gate_inv_r;

  logic [NGATE-1:0]  data_in;
  logic [NGATE-1:0]  gate;
  logic              comb_res;
  logic              state_nxt;
  logic              final_nxt;
  logic              g1_rise;
  logic              wr_en;
  logic              rd_setup;
  logic              rise_ev;
  logic              fall_ev;
  lcc_mode_t         mode;

  assign mode  = lcc_mode_t'(control_r[CTL_MODE_HI:0]);
  assign wr_en = psel_i & penable_i & pwrite_i & pready_r;

  ////////////////////////////////////////////////////////////////////////////
  // gating function: OR of enabled true/negated terms, then gate inversion
  // with the invert bit set over negated terms the gate is an AND of the
  // inputs, over true terms a NOR; with no term enabled the invert bit alone
  // gives the level. Enabling both forms of one input makes the OR always
  // true, so the gate then sits at the inverse of its invert bit.
  function automatic logic gate_fn(input logic [7:0] sel_bits,
                                   input logic [NGATE-1:0] d,
                                   input logic inv);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < NGATE; i++) begin
      acc = acc | (sel_bits[2*i+1] & d[i]) | (sel_bits[2*i] & ~d[i]);
    end
    return acc ^ inv;
  endfunction : gate_fn

  // is an apb address one of a bank of four registers
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(NGATE) * OFS_STEP) && (a[1:0] == 2'b00);
  endfunction : in_bank

  // data selection and gate stage; unmatched codes read zero
  always_comb begin
    for (int i = 0; i < NGATE; i++) begin
      data_in[i] = (int'(sel_r[i][SEL_W-1:0]) < IN_W) ?
                   cell_in_i[sel_r[i][SEL_W-1:0]] : 1'b0;
    end
    for (int i = 0; i < NGATE; i++) begin
      gate[i] = gate_fn(gls_r[i], data_in, polarity_r[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // logic function stage; stateful modes sampled on the core clock, so gate
  // pulses shorter than one clock period are not seen (sampled model)
  //
  // gate roles in the stateful modes, gate[0] being the first gate:
  //   011 latch:      set gate[0] | gate[1], reset gate[2] | gate[3]
  //   100 flip-flop:  clock gate[0], data gate[1], reset gate[2], set gate[3]
  //   101 flip-flop:  clock gate[0], data gate[1] & gate[3], reset gate[2]
  //   110 j-k:        clock gate[0], j gate[1], k gate[3], reset gate[2]
  //   111 latch:      enable gate[0], data gate[1], reset gate[2], set gate[3]
  // set and reset act without waiting for the clock gate; set beats reset
  assign g1_rise = gate[0] & ~g1_prev_r;

  always_comb begin
    comb_res  = 1'b0;
    state_nxt = state_r;
    case (mode)
      LCC_AND_OR:   comb_res = (gate[0] & gate[1]) | (gate[2] & gate[3]);
      LCC_OR_XOR:   comb_res = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
      LCC_AND4:     comb_res = &gate;
      LCC_SR_LATCH: begin
        // set dominates when both asserted
        if (gate[0] | gate[1]) state_nxt = 1'b1;
        else if (gate[2] | gate[3]) state_nxt = 1'b0;
      end
      LCC_DFF_SR: begin
        if (gate[3]) state_nxt = 1'b1;
        else if (gate[2]) state_nxt = 1'b0;
        else if (g1_rise) state_nxt = gate[1];
      end
      LCC_DFF2_R: begin
        if (gate[2]) state_nxt = 1'b0;
        else if (g1_rise) state_nxt = gate[1] & gate[3];
      end
      LCC_JK_R: begin
        if (gate[2]) state_nxt = 1'b0;
        else if (g1_rise) begin
          case ({gate[1], gate[3]})
            2'b10:   state_nxt = 1'b1;
            2'b01:   state_nxt = 1'b0;
            2'b11:   state_nxt = ~state_r;
            default: state_nxt = state_r;
          endcase
        end
      end
      LCC_LATCH_SR: begin
        if (gate[3]) state_nxt = 1'b1;
        else if (gate[2]) state_nxt = 1'b0;
        else if (gate[0]) state_nxt = gate[1];
      end
      default: comb_res = 1'b0;
    endcase
  end

  // output select, polarity and enable
  always_comb begin
    if (!control_r[CTL_EN]) begin
      final_nxt = 1'b0;
    end else if (mode[2] | (mode == LCC_SR_LATCH)) begin
      final_nxt = state_nxt ^ polarity_r[POL_OUT_INV];
    end else begin
      final_nxt = comb_res ^ polarity_r[POL_OUT_INV];
    end
  end

  // cell state only advances while enabled, so stale config cannot corrupt it
  // reset clears the stored bit and the gate-1 history, so no false clock follows
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r   <= 1'b0;
      g1_prev_r <= 1'b0;
    end else begin
      g1_prev_r <= gate[0];
      if (control_r[CTL_EN]) begin
        state_r <= state_nxt;
      end
    end
  end

  // final output flop, fed to pin, peers and own input bus outside
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cell_out_r <= 1'b0;
    end else begin
      cell_out_r <= final_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detectors on the final output; a polarity flip also shows here
  // the next output is compared with the registered one, so the flag sets on
  // the edge where the output flop changes; a disable can show as a fall too
  assign rise_ev = final_nxt & ~cell_out_r;
  assign fall_ev = ~final_nxt & cell_out_r;

  // sticky flag: set wins over a same-cycle software clear
  // the flag keeps recording edges while the request is masked, so software
  // that enables the request late still sees an edge that came before
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_flag_r <= 1'b0;
    end else if ((rise_ev & control_r[CTL_RISE]) | (fall_ev & control_r[CTL_FALL])) begin
      irq_flag_r <= 1'b1;
    end else if (wr_en && paddr_i == OFS_IRQ && pwdata_i[IRQ_FLAG]) begin
      irq_flag_r <= 1'b0;
    end
  end

  // request gating by all enables
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_flag_r & control_r[CTL_EN] & cell_ie_r & periph_ie_r & global_ie_r;
    end
  end

  // oscillator keep-alive request while enabled and selected
  // only the selects count: the request does not care whether that oscillator
  // also clocks the core, since the cell must keep running either way
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      osc_keep_r <= 1'b0;
    end else begin
      osc_keep_r <= 1'b0;
      for (int i = 0; i < NGATE; i++) begin
        if (control_r[CTL_EN] && sel_r[i][SEL_W-1:0] == FAST_OSC_SEL) begin
          osc_keep_r <= 1'b1;
        end
      end
    end
  end

  // all cell outputs captured on one edge so a read has no skew
  // the snapshot is two clocks old when the master takes it, the price of a registered read path
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mirror_r <= '0;
    end else begin
      mirror_r <= peer_out_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: cleared by reset, output bit is not writable
  // changing the mode while enabled is allowed, but the output may show one
  // cycle of the new function acting on the old stored state
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      control_r <= CTL_RESET;
    end else if (wr_en && paddr_i == OFS_CONTROL) begin
      control_r <= pwdata_i[7:0] & CTL_WMASK;
    end
  end

  // polarity: output invert cleared by reset, gate inverts kept
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      out_inv_r <= 1'b0;
    end else if (wr_en && paddr_i == OFS_POLARITY) begin
      out_inv_r <= pwdata_i[POL_OUT_INV];
    end
  end

  // gate inverts have no reset value, like the selects and gates
  always_ff @(posedge core_clk_i) begin
    if (wr_en && paddr_i == OFS_POLARITY) begin
      gate_inv_r <= pwdata_i[6:0] & POL_WMASK[6:0];
    end
  end

  // unused bits 6:4 stay zero through the write mask
  assign polarity_r = {out_inv_r, gate_inv_r};

  // selects and gates deliberately ignore reset
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NGATE; i++) begin
      if (wr_en && paddr_i == OFS_SEL0 + 8'(i) * OFS_STEP) begin
        sel_r[i] <= pwdata_i[7:0] & SEL_WMASK;
      end
      if (wr_en && paddr_i == OFS_GLS0 + 8'(i) * OFS_STEP) begin
        gls_r[i] <= pwdata_i[7:0];
      end
    end
  end

  // interrupt enables
  // bit 1 cell, bit 2 peripheral, bit 3 global; bit 0 of a write is the
  // flag clear and is handled with the flag
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cell_ie_r   <= 1'b0;
      periph_ie_r <= 1'b0;
      global_ie_r <= 1'b0;
    end else if (wr_en && paddr_i == OFS_IRQ) begin
      cell_ie_r   <= pwdata_i[IRQ_CELL_EN];
      periph_ie_r <= pwdata_i[IRQ_PERIPH_EN];
      global_ie_r <= pwdata_i[IRQ_GLOBAL_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: read data and ready registered in setup, so access ends in one cycle
  // map, one register per word, upper bits read zero: 0x00 control,
  // 0x04 polarity, 0x08-0x14 data selects, 0x18-0x24 gate selects,
  // 0x28 flag (write one to clear) and enables, 0x2C mirror
  // unmapped or misaligned addresses answer with an error and change nothing;
  // ready is never held low, so a master never waits more than one cycle
  assign rd_setup = psel_i & ~penable_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= rd_setup;
      pslverr_r <= 1'b0;
      if (rd_setup) begin
        prdata_r <= '0;
        if (paddr_i == OFS_CONTROL) begin
          prdata_r[7:0] <= {control_r[7:6], cell_out_r, control_r[4:0]};
        end else if (paddr_i == OFS_POLARITY) begin
          prdata_r[7:0] <= polarity_r & POL_WMASK;
        end else if (in_bank(paddr_i, OFS_SEL0)) begin
          prdata_r[7:0] <= sel_r[2'((paddr_i - OFS_SEL0) >> 2)];
        end else if (in_bank(paddr_i, OFS_GLS0)) begin
          prdata_r[7:0] <= gls_r[2'((paddr_i - OFS_GLS0) >> 2)];
        end else if (paddr_i == OFS_IRQ) begin
          prdata_r[3:0] <= {global_ie_r, periph_ie_r, cell_ie_r, irq_flag_r};
        end else if (paddr_i == OFS_MIRROR) begin
          prdata_r[NCELL-1:0] <= mirror_r;
        end else begin
          pslverr_r <= 1'b1;
        end
      end
    end
  end

  assign prdata_o   = prdata_r;
  assign pready_o   = pready_r;
  assign pslverr_o  = pslverr_r;
  assign cell_out_o = cell_out_r;
  assign irq_o      = irq_r;
  assign osc_keep_o = osc_keep_r;
endmodule : lcc_core

// ### tb/lcc_pins_model.sv
// pins and peripheral outputs seen at the cell input bus, plus the peer output loop
`timescale 1ns/100ps
module lcc_pins_model (
  input  wire logic        pin_i,
  input  wire logic        cell_out_i,
  output logic [63:0]      cell_in_o,
  output logic [3:0]       peer_out_o
);
  // bit 0 is the probed pin; the others hold a busy peripheral pattern
  assign cell_in_o  = {60'hA5A5A5A5A5A5A5A, 3'b110, pin_i};
  // this cell's own output returns as peer 0 beside three fixed neighbours
  assign peer_out_o = {3'b101, cell_out_i};
endmodule : lcc_pins_model

// ### tb/lcc_core_asserts.sv
// port-level assertion checker for the logic cell core
`timescale 1ns/100ps
module lcc_chk #(
  parameter int unsigned NCELL = 4
) (
  input wire logic                       core_clk_i,
  input wire logic                       srst_i,
  input wire logic [NCELL-1:0]           peer_out_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [lcc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0]                pwdata_i,
  input wire logic [31:0]                prdata_o,
  input wire logic                       pready_o,
  input wire logic                       cell_out_o,
  input wire logic                       irq_o,
  input wire logic                       osc_keep_o
);
  import lcc_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  logic wr_done;
  logic rd_setup;
  // a write lands only at the access edge that sees ready
  assign wr_done  = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  a_disable_zero: assert property (
    wr_done && paddr_i == OFS_CONTROL && !pwdata_i[CTL_EN] |-> ##[1:2] !cell_out_o)
    else $error("output not low after disable");
  a_irq_cell_en: assert property (
    wr_done && paddr_i == OFS_CONTROL && !pwdata_i[CTL_EN] |-> ##[1:3] !irq_o)
    else $error("request stays up on disabled cell");
  a_irq_all_en: assert property (
    wr_done && paddr_i == OFS_IRQ && !(&pwdata_i[3:1]) |-> ##[1:2] !irq_o)
    else $error("request without all enables");
  a_osc_release: assert property (
    wr_done && paddr_i == OFS_CONTROL && !pwdata_i[CTL_EN] |-> ##[1:2] !osc_keep_o)
    else $error("oscillator held by disabled cell");
  a_reset_quiet: assert property (
    $fell(srst_i) |-> (!cell_out_o && !irq_o && !osc_keep_o) [*3])
    else $error("outputs active right after reset");
  a_mirror_snap: assert property (
    rd_setup && paddr_i == OFS_MIRROR
    |=> prdata_o == {{(32-NCELL){1'b0}}, $past(peer_out_i, 2)})
    else $error("mirror read is not one snapshot");
  a_out_bit: assert property (
    rd_setup && paddr_i == OFS_CONTROL |=> prdata_o[CTL_OUT] == $past(cell_out_o))
    else $error("control output bit differs from cell output");
  a_ready_prompt: assert property (
    psel_i && !penable_i |=> pready_o)
    else $error("no ready in first access cycle");
endmodule : lcc_chk

// ### tb/lcc_core_bench.sv
// self-checking bench: register-driven tests of the logic cell core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module lcc_core_bench;
  import lcc_pkg::*;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pin = 0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, cell_out, irq, osc_keep, errv, e;
  logic [63:0] cell_in;
  logic [3:0]  peer_out, g;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  // setup writes; disable first, then data selects and gate selects, no enable
  localparam logic [15:0] CFG [9] = '{16'h0000, 16'h0800, 16'h0C01, 16'h1002,
    16'h1403, 16'h1802, 16'h1C00, 16'h2000, 16'h2400};
  // sequential steps: mode, gate inverts, pin, expected output
  localparam logic [8:0] ST [24] = '{9'h0D0, 9'h0C3, 9'h0C1, 9'h0D0, 9'h110, 9'h108,
    9'h10B, 9'h110, 9'h121, 9'h150, 9'h168, 9'h16B, 9'h149, 9'h14A, 9'h190, 9'h188,
    9'h18B, 9'h1A9, 9'h1AA, 9'h1D0, 9'h1CB, 9'h1C1, 9'h1C2, 9'h1E1};
  lcc_core dut (.core_clk_i(clk), .srst_i(srst), .cell_in_i(cell_in), .peer_out_i(peer_out),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cell_out_o(cell_out), .irq_o(irq), .osc_keep_o(osc_keep));
  lcc_pins_model pins (.pin_i(pin), .cell_out_i(cell_out), .cell_in_o(cell_in),
    .peer_out_o(peer_out));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // apb master: request held until ready, one idle edge after each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // output seen both on the pin and in the control read-back
  task automatic out_is(input logic x);
    repeat (3) @(posedge clk);
    rd(OFS_CONTROL);
    `CHK("out_bit", x, rdv[CTL_OUT])
    `CHK("cell_out", x, cell_out)
  endtask : out_is
  // request expected only while every enable is set
  task automatic irq_is(input logic f);
    repeat (3) @(posedge clk);
    rd(OFS_IRQ);
    `CHK("flag", f, rdv[IRQ_FLAG])
    `CHK("irq", f & (&rdv[3:1]), irq)
  endtask : irq_is
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_CONTROL);
    `CHK("ctl_reset", 32'h0, rdv)
    foreach (CFG[i]) wr(CFG[i][15:8], CFG[i][7:0]);
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 16; p++) begin
        g = p[3:0];
        wr(OFS_POLARITY, {4'h0, g});
        wr(OFS_CONTROL, {5'b10000, m[2:0]});
        e = (m == 0) ? ((g[0] & g[1]) | (g[2] & g[3])) :
            (m == 1) ? ((g[0] | g[1]) ^ (g[2] | g[3])) : &g;
        out_is(e);
      end
    end
    $display("test combinational done");
    foreach (ST[i]) begin
      wr(OFS_CONTROL, {5'b10000, ST[i][8:6]});
      pin <= ST[i][1];
      repeat (3) @(posedge clk);
      wr(OFS_POLARITY, {4'h0, ST[i][5:2]});
      out_is(ST[i][0]);
    end
    $display("test sequential done");
    pin <= 1'b0;
    wr(OFS_POLARITY, 8'h8E);
    wr(OFS_CONTROL, 8'h82);
    out_is(1'b1);
    pin <= 1'b1;
    out_is(1'b0);
    wr(OFS_CONTROL, 8'h62);
    out_is(1'b0);
    `CHK("ctl_ro", 32'h02, rdv)
    $display("test polarity done");
    pin <= 1'b0;
    wr(OFS_IRQ, 8'h0E);
    wr(OFS_CONTROL, 8'h92);
    wr(OFS_POLARITY, 8'h0E);
    wr(OFS_IRQ, 8'h0F);
    pin <= 1'b1;
    irq_is(1'b1);
    wr(OFS_IRQ, 8'h0F);
    irq_is(1'b0);
    pin <= 1'b0;
    irq_is(1'b0);
    wr(OFS_CONTROL, 8'h8A);
    pin <= 1'b1;
    irq_is(1'b0);
    pin <= 1'b0;
    irq_is(1'b1);
    wr(OFS_IRQ, 8'h0B);
    wr(OFS_POLARITY, 8'h8E);
    wr(OFS_POLARITY, 8'h0E);
    irq_is(1'b1);
    // a falling edge lands on the very edge that clears the flag
    wr(OFS_POLARITY, 8'h8E);
    fork
      wr(OFS_IRQ, 8'h0F);
      begin
        @(posedge clk);
        pin <= 1'b1;
      end
    join
    irq_is(1'b1);
    wr(OFS_POLARITY, 8'h0E);
    pin <= 1'b0;
    out_is(1'b0);
    $display("test interrupt done");
    rd(OFS_MIRROR);
    `CHK("mirror0", 32'h0A, rdv)
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_MIRROR);
    `CHK("mirror1", 32'h0B, rdv)
    wr(8'h14, 8'h34);
    repeat (3) @(posedge clk);
    `CHK("osc_on", 1'b1, osc_keep)
    wr(OFS_CONTROL, 8'h0A);
    repeat (3) @(posedge clk);
    `CHK("osc_off", 1'b0, osc_keep)
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_CONTROL);
    `CHK("ctl_cleared", 32'h0, rdv)
    rd(8'h14);
    `CHK("sel_kept", 32'h34, rdv)
    rd(OFS_GLS0);
    `CHK("gate_kept", 32'h02, rdv)
    rd(8'h30);
    `CHK("unmapped", 33'h100000000, {errv, rdv})
    $display("test misc done");
    final_report();
  end
endmodule : lcc_core_bench
bind lcc_core lcc_chk #(.NCELL(NCELL)) u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .peer_out_i(peer_out_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .cell_out_o(cell_out_o), .irq_o(irq_o), .osc_keep_o(osc_keep_o));
